// ### irc_regs.vh
`ifndef IRC_REGS_VH
`define IRC_REGS_VH

// Register byte offsets on the plain register port
`define IRC_A_EDGE1     8'h00
`define IRC_A_EDGE2     8'h01
`define IRC_A_PMODE1    8'h02
`define IRC_A_PMODE5    8'h03
`define IRC_A_IEN       8'h04
`define IRC_A_IRQF      8'h05
`define IRC_A_WKPF      8'h06
`define IRC_A_PEN       8'h07
`define IRC_A_PFLG      8'h08
`define IRC_A_STAT      8'h09
`define IRC_A_WVEC      8'h0A

// Field positions
`define IRC_B_NMI_EDGE  7
`define IRC_B_TMR       7
`define IRC_B_SLP       6
`define IRC_B_WKEN      5

// Reset values
`define IRC_RST_EDGE1   8'h00
`define IRC_RST_EDGE2   8'h00
`define IRC_RST_PMODE   8'h00
`define IRC_RST_IEN     8'h00
`define IRC_RST_FLAG    8'h00

// Source slots in the priority table, lowest index wins
`define IRC_S_NMI       0
`define IRC_S_ABRK      1
`define IRC_S_EXT0      2
`define IRC_S_WKP       6
`define IRC_S_TMR       7
`define IRC_S_SLP       8
`define IRC_S_PER0      9
`define IRC_VEC_BASE    6'h07

// Acceptance sequence lengths in states (one state is one clock)
`define IRC_ST_PUSH     3'h4
`define IRC_ST_VEC      3'h2
`define IRC_ST_INT      3'h4
`define IRC_ST_FETCH    3'h4

`endif

// ### irc_edge_det.v
`timescale 1ns/1ns
`default_nettype none

module irc_edge_det #(
  parameter W = 11
) (
  input  wire         clk,    // core clock
  input  wire         rst_n,  // synchronised reset
  input  wire [W-1:0] pin,    // raw pins, idle high
  input  wire [W-1:0] sel,    // 1 rising, 0 falling
  input  wire [W-1:0] gate,   // pin used as interrupt input
  output reg  [W-1:0] hit_r   // one-cycle edge pulse
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      reg  s1_r;
      reg  s2_r;
      reg  lvl_r;
      // A pin not in interrupt use looks idle high, so switching the
      // function can itself look like an edge.
      wire eff = gate[i] ? s2_r : 1'b1;
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1_r     <= 1'b1;
          s2_r     <= 1'b1;
          lvl_r    <= 1'b1;
          hit_r[i] <= 1'b0;
        end
        else
        begin
          s1_r     <= pin[i];
          s2_r     <= s1_r;
          lvl_r    <= eff;
          hit_r[i] <= (eff != lvl_r) && (eff == sel[i]);
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ### irc_accept_seq.v
`timescale 1ns/1ns
`default_nettype none
`include "irc_regs.vh"

module irc_accept_seq (
  input  wire        clk,          // core clock
  input  wire        rst_n,        // synchronised reset
  input  wire        take,         // start acceptance
  input  wire [5:0]  take_vec,     // vector number
  input  wire [15:0] sp,           // stack pointer
  input  wire [15:0] ret_pc,       // return address
  input  wire [7:0]  ccr_val,      // condition codes to save
  input  wire [15:0] mem_rdata,    // read data, cycle after read
  output reg  [15:0] mem_addr_r,   // memory address
  output reg  [15:0] mem_wdata_r,  // memory write word
  output reg         mem_wr_r,     // word write strobe
  output reg         mem_rd_r,     // word read strobe
  output reg         ibit_set_r,   // set mask bit pulse
  output reg         pc_load_r,    // load handler address pulse
  output reg  [15:0] pc_val_r,     // handler start address
  output reg         busy_r        // sequence running
);

  localparam ST_IDLE  = 5'h01;
  localparam ST_PUSH  = 5'h02;
  localparam ST_VEC   = 5'h04;
  localparam ST_INT   = 5'h08;
  localparam ST_FETCH = 5'h10;

  reg [4:0]  st_r;
  reg [2:0]  cnt_r;
  reg [5:0]  vec_r;
  reg        rd_dly_r;
  wire [15:0] sp_even = sp & 16'hFFFE;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= ST_IDLE;
      cnt_r <= 3'h0;
      vec_r <= 6'h00;
      rd_dly_r <= 1'b0;
      mem_addr_r <= 16'h0000;
      mem_wdata_r <= 16'h0000;
      mem_wr_r <= 1'b0;
      mem_rd_r <= 1'b0;
      ibit_set_r <= 1'b0;
      pc_load_r <= 1'b0;
      pc_val_r <= 16'h0000;
      busy_r <= 1'b0;
    end
    else
    begin
      mem_wr_r <= 1'b0;
      mem_rd_r <= 1'b0;
      ibit_set_r <= 1'b0;
      pc_load_r <= 1'b0;
      rd_dly_r <= mem_rd_r;
      if (rd_dly_r)
        pc_val_r <= mem_rdata;
      cnt_r <= cnt_r + 3'h1;
      case (st_r)
        ST_IDLE:
        begin
          cnt_r <= 3'h0;
          if (take)
          begin
            st_r <= ST_PUSH;
            vec_r <= take_vec;
            busy_r <= 1'b1;
          end
        end
        ST_PUSH:
        begin
          if (cnt_r == 3'h0)
          begin
            mem_wr_r <= 1'b1;
            mem_addr_r <= sp_even - 16'h0002;
            mem_wdata_r <= ret_pc;
          end
          if (cnt_r == 3'h1)
          begin
            mem_wr_r <= 1'b1;
            mem_addr_r <= sp_even - 16'h0004;
            mem_wdata_r <= {ccr_val, ccr_val};
          end
          if (cnt_r == `IRC_ST_PUSH - 3'h1)
          begin
            ibit_set_r <= 1'b1;
            st_r <= ST_VEC;
            cnt_r <= 3'h0;
          end
        end
        ST_VEC:
        begin
          if (cnt_r == 3'h0)
          begin
            mem_rd_r <= 1'b1;
            mem_addr_r <= {9'h000, vec_r, 1'b0};
          end
          if (cnt_r == `IRC_ST_VEC - 3'h1)
          begin
            st_r <= ST_INT;
            cnt_r <= 3'h0;
          end
        end
        ST_INT:
        begin
          if (cnt_r == `IRC_ST_INT - 3'h1)
          begin
            st_r <= ST_FETCH;
            cnt_r <= 3'h0;
          end
        end
        ST_FETCH:
        begin
          if (cnt_r == `IRC_ST_FETCH - 3'h1)
          begin
            pc_load_r <= 1'b1;
            busy_r <= 1'b0;
            st_r <= ST_IDLE;
          end
        end
        default:
        begin
          st_r <= ST_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ### irc_top.v
// Overview of operation
// - Non-maskable pin edge is rising or falling by its own select bit.
// - Non-maskable request has top priority and ignores the mask bit.
// - Four request pins each have own vector and own edge select.
// - Selected edge on an interrupt-mode request pin sets its flag.
// - Each request pin source has its own enable bit.
// - Six wake-up pins share one vector, each with own edge select.
// - Selected edge on an interrupt-mode wake-up pin sets its flag.
// - One common enable masks all six wake-up sources.
// - Peripheral sources set a flag; clearing their enable masks them.
// - Timer and sleep-transfer flags and enables sit in shared registers.
// - A request reaches priority only if non-maskable, break, or enabled.
// - Only the highest-priority request is presented; others stay pending.
// - Non-maskable and break always taken; others only with mask bit 0.
// - Acceptance waits for instruction end, then pushes PC and CONDITION_CODE_REGISTER.
// - The saved PC is the return address.
// - Mask bit is set after the push; return restores saved CONDITION_CODE_REGISTER.
// - Vector is fetched and the handler address loaded into PC.
// - Flag set to first handler instruction takes 15 to 37 states.
// - After reset all interrupts, even non-maskable, stay off until the first instruction ends.
// - Stack accesses are words with address bit zero forced low.
// - Rewriting a pin's port mode may set its request flag.
// - Pin request flags reset to 0 and clear only by writing 0.
`timescale 1ns/1ns
`default_nettype none
`include "irc_regs.vh"

module irc_top #(
  parameter NP = 4
) (
  input  wire          core_clk,          // system clock
  input  wire          rst_n,             // chip reset, active low
  input  wire [7:0]    reg_addr,          // register address
  input  wire [7:0]    reg_wdata,         // register write data
  input  wire          reg_wr,            // write strobe
  input  wire          reg_rd,            // read strobe
  output reg  [7:0]    reg_rdata_r,       // read data, next cycle
  input  wire          nmi_pin,           // non-maskable request pin
  input  wire [3:0]    ext_request_pin,   // external request pins
  input  wire [5:0]    wakeup_pin,        // wake-up pins
  input  wire          abrk_req,          // address break request level
  input  wire          timer_ovf_evt,     // interval timer event pulse
  input  wire          sleep_xfer_evt,    // sleep direct-transfer pulse
  input  wire [NP-1:0] periph_evt,        // other peripheral event pulses
  input  wire          insn_done,         // current instruction ends
  input  wire          ccr_ibit,          // mask bit of the CONDITION_CODE_REGISTER
  input  wire [7:0]    ccr_val,           // CONDITION_CODE_REGISTER value to save
  input  wire [15:0]   ret_pc,            // return address
  input  wire [15:0]   sp,                // stack pointer
  input  wire [15:0]   mem_rdata,         // memory read word
  output wire [15:0]   mem_addr_r,        // memory address
  output wire [15:0]   mem_wdata_r,       // memory write word
  output wire          mem_wr_r,          // memory write strobe
  output wire          mem_rd_r,          // memory read strobe
  output wire          ibit_set_r,        // set the mask bit
  output wire          pc_load_r,         // load handler start address
  output wire [15:0]   pc_val_r,          // handler start address
  output reg           irq_pending_r,     // request presented to CPU
  output reg  [5:0]    irq_vec_r          // its vector number
);

  localparam NS = 9 + NP;

  // Reset release through two flops
  reg rst_s1_r;
  reg rst_s2_r;
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire srst_n = rst_s2_r;

  // Software registers
  reg [7:0]    edge_select_reg_one;
  reg [5:0]    edge_select_reg_two;
  reg [3:0]    port_mode_reg_one;
  reg [5:0]    port_mode_reg_five;
  reg [7:0]    interrupt_enable_register;
  reg [7:0]    request_flag_register;
  reg [5:0]    wakeup_flag_register;
  reg [NP-1:0] periph_en_r;
  reg [NP-1:0] periph_flag_r;
  reg          nmi_flag_r;
  reg          armed_r;

  wire         nmi_edge_select     = edge_select_reg_one[`IRC_B_NMI_EDGE];
  wire [3:0]   ext_req_edge_select = edge_select_reg_one[3:0];
  wire [5:0]   wakeup_edge_select  = edge_select_reg_two;
  wire [3:0]   ext_req_enable      = interrupt_enable_register[3:0];
  wire         wakeup_common_enable = interrupt_enable_register[`IRC_B_WKEN];
  wire [3:0]   ext_req_flag        = request_flag_register[3:0];

  wire wr_ok = reg_wr & srst_n;
  wire wr_edge1 = wr_ok && (reg_addr == `IRC_A_EDGE1);
  wire wr_edge2 = wr_ok && (reg_addr == `IRC_A_EDGE2);
  wire wr_pm1   = wr_ok && (reg_addr == `IRC_A_PMODE1);
  wire wr_pm5   = wr_ok && (reg_addr == `IRC_A_PMODE5);
  wire wr_ien   = wr_ok && (reg_addr == `IRC_A_IEN);
  wire wr_irqf  = wr_ok && (reg_addr == `IRC_A_IRQF);
  wire wr_wkpf  = wr_ok && (reg_addr == `IRC_A_WKPF);
  wire wr_pen   = wr_ok && (reg_addr == `IRC_A_PEN);
  wire wr_pflg  = wr_ok && (reg_addr == `IRC_A_PFLG);

  // Pin edge detection: bit 0 is the non-maskable pin, then 4 + 6 pins
  wire [10:0] pin_hit;
  irc_edge_det #(
    .W (11)
  ) u_edge (
    .clk   (core_clk),
    .rst_n (srst_n),
    .pin   ({wakeup_pin, ext_request_pin, nmi_pin}),
    .sel   ({wakeup_edge_select, ext_req_edge_select, nmi_edge_select}),
    .gate  ({port_mode_reg_five, port_mode_reg_one, 1'b1}),
    .hit_r (pin_hit)
  );
  wire       nmi_hit = pin_hit[0];
  wire [3:0] ext_hit = pin_hit[4:1];
  wire [5:0] wkp_hit = pin_hit[10:5];

  // Acceptance control
  wire        seq_busy;
  reg  [NS-1:0] req;
  reg  [5:0]  win_idx;
  reg         win_valid;
  reg         win_nomask;
  wire        win_ok = win_valid & (win_nomask | ~ccr_ibit);
  wire        take = armed_r & insn_done & ~seq_busy & win_ok;
  wire        take_nmi = take && (win_idx == `IRC_S_NMI);

  // Gate each source except non-maskable and break with its enable before priority
  always @*
  begin
    req = {NS{1'b0}};
    req[`IRC_S_NMI]  = nmi_flag_r;
    req[`IRC_S_ABRK] = abrk_req;
    req[`IRC_S_EXT0 +: 4] = ext_req_flag & ext_req_enable;
    req[`IRC_S_WKP]  = (|wakeup_flag_register) & wakeup_common_enable;
    req[`IRC_S_TMR]  = request_flag_register[`IRC_B_TMR]
                       & interrupt_enable_register[`IRC_B_TMR];
    req[`IRC_S_SLP]  = request_flag_register[`IRC_B_SLP]
                       & interrupt_enable_register[`IRC_B_SLP];
    req[`IRC_S_PER0 +: NP] = periph_flag_r & periph_en_r;
  end

  // Lowest slot wins; the slot order is the priority table
  integer i;
  always @*
  begin
    win_idx = 6'h00;
    win_valid = 1'b0;
    for (i = NS - 1; i >= 0; i = i - 1)
    begin
      if (req[i])
      begin
        win_idx = i[5:0];
        win_valid = 1'b1;
      end
    end
    win_nomask = (win_idx == `IRC_S_NMI) || (win_idx == `IRC_S_ABRK);
  end

  // Vector number follows the slot, so each pin has its own vector
  // while all wake-up pins share slot IRC_S_WKP.
  wire [5:0] win_vec = `IRC_VEC_BASE + win_idx;

  // Configuration registers
  always @(posedge core_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      edge_select_reg_one <= `IRC_RST_EDGE1;
      edge_select_reg_two <= 6'h00;
      port_mode_reg_one <= 4'h0;
      port_mode_reg_five <= 6'h00;
      interrupt_enable_register <= `IRC_RST_IEN;
      periph_en_r <= {NP{1'b0}};
    end
    else
    begin
      if (wr_edge1)
        edge_select_reg_one <= {reg_wdata[7], 3'h0, reg_wdata[3:0]};
      if (wr_edge2)
        edge_select_reg_two <= reg_wdata[5:0];
      if (wr_pm1)
        port_mode_reg_one <= reg_wdata[3:0];
      if (wr_pm5)
        port_mode_reg_five <= reg_wdata[5:0];
      if (wr_ien)
        interrupt_enable_register <= {reg_wdata[7:5], 1'b0, reg_wdata[3:0]};
      if (wr_pen)
        periph_en_r <= reg_wdata[NP-1:0];
    end
  end

  // Flag masks: a write of 0 clears a bit, a write of 1 leaves it.
  // A set arriving in the same cycle wins over the clear.
  wire [7:0] irqf_keep = wr_irqf ? reg_wdata : 8'hFF;
  wire [7:0] wkpf_keep = wr_wkpf ? reg_wdata : 8'hFF;
  wire [7:0] pflg_keep = wr_pflg ? reg_wdata : 8'hFF;

  wire [7:0] irqf_set = {timer_ovf_evt, sleep_xfer_evt, 2'b00, ext_hit};
  wire [7:0] irqf_nxt = (request_flag_register & irqf_keep & 8'hCF)
                        | irqf_set;
  wire [5:0] wkpf_nxt = (wakeup_flag_register & wkpf_keep[5:0])
                        | wkp_hit;
  wire [NP-1:0] pflg_nxt = (periph_flag_r & pflg_keep[NP-1:0])
                           | periph_evt;

  always @(posedge core_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      request_flag_register <= `IRC_RST_FLAG;
      wakeup_flag_register <= 6'h00;
      periph_flag_r <= {NP{1'b0}};
    end
    else
    begin
      request_flag_register <= irqf_nxt;
      wakeup_flag_register <= wkpf_nxt;
      periph_flag_r <= pflg_nxt;
    end
  end

  // Non-maskable pending flag; cleared by acceptance. Edges before the
  // first instruction completes are dropped, since the stack pointer may
  // still be unset.
  always @(posedge core_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      nmi_flag_r <= 1'b0;
      armed_r <= 1'b0;
    end
    else
    begin
      if (insn_done)
        armed_r <= 1'b1;
      if (nmi_hit && armed_r)
        nmi_flag_r <= 1'b1;
      else if (take_nmi)
        nmi_flag_r <= 1'b0;
    end
  end

  // Request presented to the CPU
  always @(posedge core_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      irq_pending_r <= 1'b0;
      irq_vec_r <= 6'h00;
    end
    else
    begin
      irq_pending_r <= win_ok & armed_r;
      irq_vec_r <= win_vec;
    end
  end

  // Read port, data stands the cycle after the strobe
  reg [7:0] rd_mux;
  always @*
  begin
    rd_mux = 8'h00;
    case (reg_addr)
      `IRC_A_EDGE1:  rd_mux = edge_select_reg_one;
      `IRC_A_EDGE2:  rd_mux = {2'b00, edge_select_reg_two};
      `IRC_A_PMODE1: rd_mux = {4'h0, port_mode_reg_one};
      `IRC_A_PMODE5: rd_mux = {2'b00, port_mode_reg_five};
      `IRC_A_IEN:    rd_mux = interrupt_enable_register;
      `IRC_A_IRQF:   rd_mux = request_flag_register;
      `IRC_A_WKPF:   rd_mux = {2'b00, wakeup_flag_register};
      `IRC_A_PEN:    rd_mux = {{(8-NP){1'b0}}, periph_en_r};
      `IRC_A_PFLG:   rd_mux = {{(8-NP){1'b0}}, periph_flag_r};
      `IRC_A_STAT:   rd_mux = {4'h0, nmi_flag_r, armed_r, seq_busy,
                               irq_pending_r};
      `IRC_A_WVEC:   rd_mux = {2'b00, irq_vec_r};
      default:       rd_mux = 8'h00;
    endcase
  end

  always @(posedge core_clk or negedge srst_n)
  begin
    if (!srst_n)
      reg_rdata_r <= 8'h00;
    else if (reg_rd)
      reg_rdata_r <= rd_mux;
    else
      reg_rdata_r <= 8'h00;
  end

  // Stack push, mask set, vector fetch and handler start
  irc_accept_seq u_seq (
    .clk         (core_clk),
    .rst_n       (srst_n),
    .take        (take),
    .take_vec    (win_vec),
    .sp          (sp),
    .ret_pc      (ret_pc),
    .ccr_val     (ccr_val),
    .mem_rdata   (mem_rdata),
    .mem_addr_r  (mem_addr_r),
    .mem_wdata_r (mem_wdata_r),
    .mem_wr_r    (mem_wr_r),
    .mem_rd_r    (mem_rd_r),
    .ibit_set_r  (ibit_set_r),
    .pc_load_r   (pc_load_r),
    .pc_val_r    (pc_val_r),
    .busy_r      (seq_busy)
  );

endmodule

`default_nettype wire

// ### irc_top_chk.sv
`timescale 1ns/1ns
`default_nettype none
module irc_top_chk (
  input wire logic        core_clk,     // clock
  input wire logic        rst_n,        // reset
  input wire logic        reg_rd,       // read strobe
  input wire logic [7:0]  reg_rdata_r,  // read data
  input wire logic        insn_done,    // insn end
  input wire logic        ccr_ibit,     // mask bit
  input wire logic [7:0]  ccr_val,      // codes
  input wire logic [15:0] ret_pc,       // return pc
  input wire logic [15:0] sp,           // stack
  input wire logic [15:0] mem_addr_r,   // address
  input wire logic [15:0] mem_wdata_r,  // write word
  input wire logic        mem_wr_r,     // write
  input wire logic        mem_rd_r,     // read
  input wire logic        ibit_set_r,   // set mask
  input wire logic        pc_load_r,    // load pc
  input wire logic [5:0]  irq_vec_r     // vector
);
  logic armed_seen_r;

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Nothing may be accepted before the first instruction has ended
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      armed_seen_r <= 1'b0;
    else if (insn_done)
      armed_seen_r <= 1'b1;
  end

  a_ret_push: assert property (
    $rose(mem_wr_r) |-> mem_addr_r == (sp & 16'hFFFE) - 16'h0002 && mem_wdata_r == ret_pc)
    else $error("return address push wrong");
  a_ccr_push: assert property (
    $rose(mem_wr_r) |=> mem_wr_r && mem_addr_r == (sp & 16'hFFFE) - 16'h0004
      && mem_wdata_r == {ccr_val, ccr_val}) else $error("condition code push wrong");
  a_two_pushes: assert property (
    $rose(mem_wr_r) |-> ##2 !mem_wr_r [*8]) else $error("extra stack write");
  a_mask_set: assert property (
    $rose(mem_wr_r) |-> !ibit_set_r [*3] ##1 ibit_set_r) else $error("mask bit not set");
  a_vec_read: assert property (
    $rose(mem_wr_r) |-> ##4 mem_rd_r && mem_addr_r[0] == 1'b0) else $error("vector read wrong");
  a_handler_load: assert property (
    $rose(mem_wr_r) |-> !pc_load_r [*8] ##6 pc_load_r) else $error("handler load late");
  a_masked_hold: assert property (
    $rose(mem_wr_r) && $past(ccr_ibit) |-> $past(irq_vec_r) inside {6'h07, 6'h08})
    else $error("maskable source taken with mask bit set");
  a_reset_quiet: assert property (
    !armed_seen_r |-> !mem_wr_r && !ibit_set_r && !pc_load_r) else $error("take after reset");
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata_r == 8'h00) else $error("read data not idle");

  c_masked_take: cover property ($rose(mem_wr_r) && $past(ccr_ibit));
  c_vec_read: cover property ($rose(mem_rd_r));
  c_handler: cover property (pc_load_r);
endmodule

bind irc_top irc_top_chk u_chk (.*);
`default_nettype wire

// ### irc_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module irc_cpu_model (
  input  wire logic        core_clk,    // clock
  input  wire logic        rst_n,       // reset
  input  wire logic        run,         // fetch enable
  input  wire logic        ibit_clr,    // return from handler
  input  wire logic [15:0] mem_addr_r,  // address
  input  wire logic        mem_wr_r,    // write
  input  wire logic        mem_rd_r,    // read
  input  wire logic        ibit_set_r,  // set mask
  input  wire logic        pc_load_r,   // load pc
  input  wire logic [15:0] pc_val_r,    // handler
  output logic             insn_done,   // insn end
  output logic             ccr_ibit,    // mask bit
  output logic [7:0]       ccr_val,     // codes
  output logic [15:0]      ret_pc,      // return pc
  output logic [15:0]      sp,          // stack
  output logic [15:0]      mem_rdata    // read word
);
  logic [2:0]  gap_r;
  logic        busy_r;
  logic        wn_r;
  logic [15:0] push_a [2];
  logic [15:0] vaddr;
  int          takes;

  assign sp      = 16'hFF80;
  assign ccr_val = {ccr_ibit, 7'h05};

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gap_r     <= 3'h0;
      busy_r    <= 1'b0;
      wn_r      <= 1'b0;
      insn_done <= 1'b0;
      ccr_ibit  <= 1'b1;
      ret_pc    <= 16'h0100;
      mem_rdata <= 16'h5A5A;
      takes     <= 0;
    end
    else
    begin
      // No instruction ends while exception handling owns the core
      insn_done <= run && !busy_r && gap_r == 3'h5 && !insn_done;
      gap_r     <= (insn_done || pc_load_r) ? 3'h0 : (gap_r == 3'h5 ? gap_r : gap_r + 3'h1);
      if (insn_done)
        ret_pc <= ret_pc + 16'h0002;
      if (mem_wr_r)
      begin
        busy_r       <= 1'b1;
        push_a[wn_r] <= mem_addr_r;
        wn_r         <= !wn_r;
      end
      if (ibit_set_r)
        ccr_ibit <= 1'b1;
      else if (ibit_clr)
        ccr_ibit <= 1'b0;
      // Released bus toggles so a late sample cannot pass by luck
      mem_rdata <= mem_rd_r ? {8'hA0, mem_addr_r[7:0]} : ~mem_rdata;
      if (mem_rd_r)
        vaddr <= mem_addr_r;
      if (pc_load_r)
      begin
        busy_r <= 1'b0;
        ret_pc <= pc_val_r;
        takes  <= takes + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ### test_interrupt_request_controller.sv
`timescale 1ns/1ns
`default_nettype none
module test_interrupt_request_controller;
  logic        core_clk, rst_n, reg_wr, reg_rd, nmi_pin, abrk_req, run, ibit_clr;
  logic        timer_ovf_evt, sleep_xfer_evt, insn_done, ccr_ibit, mem_wr_r, mem_rd_r;
  logic        ibit_set_r, pc_load_r, irq_pending_r;
  logic [3:0]  ext_request_pin, periph_evt;
  logic [5:0]  wakeup_pin, irq_vec_r;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata_r, ccr_val;
  logic [15:0] ret_pc, sp, mem_rdata, mem_addr_r, mem_wdata_r, pc_val_r;
  int          err_count, comparisons;

  irc_top #(.NP(4)) dut (.*);
  irc_cpu_model u_cpu (.*);

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check(what, {8'h00, exp}, {8'h00, reg_rdata_r});
  endtask

  task automatic clr;
    @(posedge core_clk);
    ibit_clr <= 1'b1;
    @(posedge core_clk);
    ibit_clr <= 1'b0;
  endtask

  task automatic pins(input logic n, input logic [3:0] e, input logic [5:0] w);
    @(posedge core_clk);
    nmi_pin         <= n;
    ext_request_pin <= e;
    wakeup_pin      <= w;
    repeat (8) @(posedge core_clk);
  endtask

  task automatic quiet(input int cyc, input string what);
    int n;
    n = u_cpu.takes;
    repeat (cyc) @(posedge core_clk);
    check(what, 16'(n), 16'(u_cpu.takes));
  endtask

  task automatic take(input logic [15:0] va);
    int n;
    n = u_cpu.takes;
    for (int i = 0; i < 100 && u_cpu.takes == n; i++)
      @(posedge core_clk);
    #1;
    check("take count", 16'(n + 1), 16'(u_cpu.takes));
    check("vector address", va, u_cpu.vaddr);
    check("handler pc", {8'hA0, va[7:0]}, u_cpu.ret_pc);
    check("mask bit", 16'h0001, {15'h0000, ccr_ibit});
    check("pc push address", 16'hFF7E, u_cpu.push_a[0]);
    check("ccr push address", 16'hFF7C, u_cpu.push_a[1]);
  endtask

  task automatic t_reset;
    for (int a = 0; a < 10; a++)
      rd(8'(a), 8'h00, "reset value");
    rd(8'h3F, 8'h00, "unmapped read");
    pins(1'b0, 4'hF, 6'h3F);
    quiet(20, "nmi before arming");
    @(posedge core_clk);
    run <= 1'b1;
    quiet(30, "armed without request");
    pins(1'b1, 4'hF, 6'h3F);
    $display("test reset done");
  endtask

  task automatic t_pins;
    wr(8'h02, 8'h0F);
    wr(8'h00, 8'h08);
    clr;
    pins(1'b1, 4'h3, 6'h3F);
    rd(8'h05, 8'h04, "falling edge flag");
    quiet(30, "pin enable off");
    pins(1'b1, 4'hB, 6'h3F);
    rd(8'h05, 8'h0C, "rising edge flag");
    wr(8'h05, 8'h08);
    rd(8'h05, 8'h08, "flag cleared by zero");
    wr(8'h04, 8'h08);
    @(posedge core_clk);
    #1 check("pending", 16'h0001, {15'h0000, irq_pending_r});
    take(16'h0018);
    rd(8'h05, 8'h08, "flag kept after take");
    wr(8'h05, 8'h00);
    pins(1'b1, 4'hF, 6'h3F);
    $display("test pins done");
  endtask

  task automatic t_prio;
    wr(8'h04, 8'h00);
    pins(1'b1, 4'hC, 6'h3E);
    wr(8'h03, 8'h01);
    quiet(8, "mode switch no take");
    rd(8'h06, 8'h01, "mode switch flag");
    wr(8'h04, 8'h23);
    clr;
    take(16'h0012);
    wr(8'h05, 8'h02);
    clr;
    take(16'h0014);
    wr(8'h05, 8'h00);
    clr;
    take(16'h001A);
    wr(8'h06, 8'h00);
    wr(8'h04, 8'h00);
    pins(1'b1, 4'hF, 6'h3F);
    $display("test priority done");
  endtask

  task automatic t_nmi;
    wr(8'h04, 8'h04);
    pins(1'b1, 4'hB, 6'h3F);
    quiet(30, "mask bit holds pin");
    wr(8'h00, 8'h88);
    pins(1'b0, 4'hB, 6'h3F);
    quiet(20, "nmi wrong edge");
    pins(1'b1, 4'hB, 6'h3F);
    take(16'h000E);
    quiet(30, "mask bit still holds pin");
    @(posedge core_clk);
    abrk_req <= 1'b1;
    take(16'h0010);
    @(posedge core_clk);
    abrk_req <= 1'b0;
    clr;
    take(16'h0016);
    wr(8'h05, 8'h00);
    wr(8'h04, 8'h00);
    pins(1'b1, 4'hF, 6'h3F);
    $display("test nmi and break done");
  endtask

  task automatic t_periph;
    clr;
    @(posedge core_clk);
    timer_ovf_evt  <= 1'b1;
    sleep_xfer_evt <= 1'b1;
    periph_evt     <= 4'h2;
    @(posedge core_clk);
    timer_ovf_evt  <= 1'b0;
    sleep_xfer_evt <= 1'b0;
    periph_evt     <= 4'h0;
    rd(8'h05, 8'hC0, "timer and sleep flags");
    rd(8'h08, 8'h02, "peripheral flag");
    quiet(30, "peripheral masked");
    wr(8'h07, 8'h02);
    take(16'h0022);
    wr(8'h08, 8'h00);
    wr(8'h04, 8'h80);
    clr;
    take(16'h001C);
    wr(8'h05, 8'h40);
    wr(8'h04, 8'h40);
    clr;
    take(16'h001E);
    $display("test peripherals done");
  endtask

  initial
  begin
    rst_n           = 1'b0;
    reg_addr        = 8'h00;
    reg_wdata       = 8'h00;
    reg_wr          = 1'b0;
    reg_rd          = 1'b0;
    nmi_pin         = 1'b1;
    ext_request_pin = 4'hF;
    wakeup_pin      = 6'h3F;
    abrk_req        = 1'b0;
    timer_ovf_evt   = 1'b0;
    sleep_xfer_evt  = 1'b0;
    periph_evt      = 4'h0;
    run             = 1'b0;
    ibit_clr        = 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset;
    t_pins;
    t_prio;
    t_nmi;
    t_periph;
    give_verdict;
  end

  // Whole sequence needs under a thousand cycles; this bound only cuts a hang
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    $display("[ERR] watchdog expected finish seen hang");
    give_verdict;
  end
endmodule
`default_nettype wire
